// >>> design/pwm_duty_smoothing_filter.sv
// Top of the two-output PWM duty smoothing filter with its register port.
`timescale 1ns/100ps
`include "smooth_cfg.svh"
module pwm_duty_smoothing_filter
    import smooth_pkg::*;
#(
    parameter int unsigned UPDATE_CYCLES = `UPDATE_PERIOD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] out1_duty_req,
    input wire logic out1_lowres,
    input wire logic [7:0] out2_duty_req,
    input wire logic out2_lowres,
    output logic [7:0] out1_duty,
    output logic out1_shut,
    output logic [7:0] out2_duty,
    output logic out2_shut
);

    //==========================================================================
    // Register state
    logic [7:0] cfg_reg;
    thresh_t thresh1_reg;
    thresh_t thresh2_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic cfg_wr;
    logic thr1_wr;
    logic thr2_wr;
    logic tick;

    smooth_lane_if lif1();
    smooth_lane_if lif2();

    // Address match of a strobe; shared by the write decode and the checks.
    function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = strobe && (addr == ofs);
    endfunction

    // Write decode for each writable register.
    assign cfg_wr = reg_hit(reg_wr, reg_addr, `OFS_SMOOTH_CFG);
    assign thr1_wr = reg_hit(reg_wr, reg_addr, `OFS_OUT1_THRESH);
    assign thr2_wr = reg_hit(reg_wr, reg_addr, `OFS_OUT2_THRESH);

    //==========================================================================
    // Configuration register: two coefficient fields, reserved bits held at zero.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= `SMOOTH_CFG_RST;
        end else if (clk_en && cfg_wr) begin
            cfg_reg <= reg_wdata & `CFG_WR_MASK;
        end
    end

    //==========================================================================
    // Shutoff threshold registers, five bits in the upper part of each byte.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            thresh1_reg <= `THRESH_RST;
            thresh2_reg <= `THRESH_RST;
        end else if (clk_en) begin
            if (thr1_wr) begin
                thresh1_reg <= reg_wdata[`THRESH_MSB:`THRESH_LSB];
            end
            if (thr2_wr) begin
                thresh2_reg <= reg_wdata[`THRESH_MSB:`THRESH_LSB];
            end
        end
    end

    //==========================================================================
    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            `OFS_SMOOTH_CFG: rdata_next = cfg_reg;
            `OFS_OUT1_THRESH: rdata_next = {thresh1_reg, 3'h0};
            `OFS_OUT2_THRESH: rdata_next = {thresh2_reg, 3'h0};
            `OFS_OUT1_LEVEL: rdata_next = lif1.level;
            `OFS_OUT2_LEVEL: rdata_next = lif2.level;
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            rdata_reg <= reg_rd ? rdata_next : 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

    //==========================================================================
    // Update timebase shared by both lanes.
    smooth_tick #(
        .PERIOD_CYCLES(UPDATE_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .tick(tick)
    );

    //==========================================================================
    // Lane hookup: each output takes its own coefficient field.
    assign lif1.coef = cfg_reg[`COEF1_MSB:`COEF1_LSB];
    assign lif1.thresh = thresh1_reg;
    assign lif1.tick = tick;
    assign lif1.duty_req = out1_duty_req;
    assign lif1.lowres = out1_lowres;
    assign lif2.coef = cfg_reg[`COEF2_MSB:`COEF2_LSB];
    assign lif2.thresh = thresh2_reg;
    assign lif2.tick = tick;
    assign lif2.duty_req = out2_duty_req;
    assign lif2.lowres = out2_lowres;

    smooth_lane u_lane1 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .lif(lif1)
    );

    smooth_lane u_lane2 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .lif(lif2)
    );

    // Outputs come straight from the lane flip-flops.
    assign out1_duty = lif1.duty_out;
    assign out1_shut = lif1.shut;
    assign out2_duty = lif2.duty_out;
    assign out2_shut = lif2.shut;

    //==========================================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // A configuration write taken by the block.
    sequence s_cfg_write;
        clk_en && cfg_wr;
    endsequence

    // A filter update taken while smoothing is active on lane 1.
    sequence s_lane1_update;
        clk_en && tick && (lif1.coef != 3'h0) && out1_lowres;
    endsequence

    // A quiet enabled cycle on lane 1 with smoothing active.
    sequence s_lane1_quiet;
        clk_en && !tick && (lif1.coef != 3'h0) && out1_lowres;
    endsequence

    // A filter update taken while smoothing is active on lane 2.
    sequence s_lane2_update;
        clk_en && tick && (lif2.coef != 3'h0) && out2_lowres;
    endsequence

    // A quiet enabled cycle on lane 2 with smoothing active.
    sequence s_lane2_quiet;
        clk_en && !tick && (lif2.coef != 3'h0) && out2_lowres;
    endsequence

    // Enabled cycles since the last update tick; the first tick after reset has no reference.
    tick_cnt_t gap_reg;
    logic gap_seen_reg;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_reg <= 20'h00000;
            gap_seen_reg <= 1'b0;
        end else if (clk_en) begin
            if (tick) begin
                gap_reg <= 20'h00000;
                gap_seen_reg <= 1'b1;
            end else begin
                gap_reg <= tick_cnt_t'(gap_reg + 20'h00001);
            end
        end
    end

    a_coef1_field: assert property (s_cfg_write |=> cfg_reg[2:0] == $past(reg_wdata[2:0]))
        else $error("First coefficient field did not take the written value.");

    a_coef2_field: assert property (s_cfg_write |=> cfg_reg[6:4] == $past(reg_wdata[6:4]))
        else $error("Second coefficient field did not take the written value.");

    a_cfg_reserved: assert property (reg_rd && clk_en && reg_addr == `OFS_SMOOTH_CFG |=>
        reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
        else $error("Reserved configuration bits read as nonzero.");

    a_bypass_pass1: assert property (clk_en && lif1.coef == 3'h0 |=> out1_duty == $past(out1_duty_req))
        else $error("Bypassed lane 1 did not pass the duty through.");

    a_bypass_pass2: assert property (clk_en && lif2.coef == 3'h0 |=> out2_duty == $past(out2_duty_req))
        else $error("Bypassed lane 2 did not pass the duty through.");

    a_update_converge: assert property (s_lane1_update |=>
        duty_dist(lif1.level, $past(out1_duty_req)) <= $past(duty_dist(lif1.level, out1_duty_req)))
        else $error("Filter update moved lane 1 away from its target.");

    a_reset_clear: assert property ($rose(rst_b) |-> cfg_reg == 8'h00 ##1 1'b1)
        else $error("Configuration register not zero after reset.");

    a_cfg_readback: assert property (reg_rd && clk_en && reg_addr == `OFS_SMOOTH_CFG |=>
        reg_rdata == $past(cfg_reg))
        else $error("Configuration read did not return the register.");

    a_read_one_cycle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data stood outside the cycle after the strobe.");

    a_shut_bypass1: assert property (clk_en && lif1.coef == 3'h0 |=> !out1_shut)
        else $error("Shutoff active on bypassed lane 1.");

    a_shut_bypass2: assert property (clk_en && lif2.coef == 3'h0 |=> !out2_shut)
        else $error("Shutoff active on bypassed lane 2.");

    a_shut_force: assert property (clk_en && lif1.coef != 3'h0 && !out1_lowres &&
        out1_duty_req < {thresh1_reg, 3'h0} |=> out1_shut && out1_duty == 8'h00)
        else $error("Lane 1 did not shut off below its threshold.");

    a_level_hold: assert property (s_lane1_quiet |=> $stable(lif1.level))
        else $error("Lane 1 level moved between updates.");

    a_tick_spacing: assert property (clk_en && tick |=> !tick)
        else $error("Update tick lasted more than one enabled cycle.");

    a_idle_track: assert property (clk_en && lif1.coef != 3'h0 && !out1_lowres |=>
        lif1.level == $past(out1_duty_req))
        else $error("Lane 1 level did not track a high resolution source.");

    a_update_converge2: assert property (s_lane2_update |=>
        duty_dist(lif2.level, $past(out2_duty_req)) <= $past(duty_dist(lif2.level, out2_duty_req)))
        else $error("Filter update moved lane 2 away from its target.");

    a_level_hold2: assert property (s_lane2_quiet |=> $stable(lif2.level))
        else $error("Lane 2 level moved between updates.");

    a_idle_track2: assert property (clk_en && lif2.coef != 3'h0 && !out2_lowres |=>
        lif2.level == $past(out2_duty_req))
        else $error("Lane 2 level did not track a high resolution source.");

    a_shut_force2: assert property (clk_en && lif2.coef != 3'h0 && !out2_lowres &&
        out2_duty_req < {thresh2_reg, 3'h0} |=> out2_shut && out2_duty == 8'h00)
        else $error("Lane 2 did not shut off below its threshold.");

    a_filter_out1: assert property (clk_en && lif1.coef != 3'h0 && out1_lowres &&
        lif1.level >= {thresh1_reg, 3'h0} |=> out1_duty == $past(lif1.level) && !out1_shut)
        else $error("Lane 1 output did not follow its filter level.");

    a_filter_out2: assert property (clk_en && lif2.coef != 3'h0 && out2_lowres &&
        lif2.level >= {thresh2_reg, 3'h0} |=> out2_duty == $past(lif2.level) && !out2_shut)
        else $error("Lane 2 output did not follow its filter level.");

    a_pass_high1: assert property (clk_en && lif1.coef != 3'h0 && !out1_lowres &&
        out1_duty_req >= {thresh1_reg, 3'h0} |=> out1_duty == $past(out1_duty_req) && !out1_shut)
        else $error("Lane 1 high resolution duty was not passed through.");

    a_pass_high2: assert property (clk_en && lif2.coef != 3'h0 && !out2_lowres &&
        out2_duty_req >= {thresh2_reg, 3'h0} |=> out2_duty == $past(out2_duty_req) && !out2_shut)
        else $error("Lane 2 high resolution duty was not passed through.");

    a_thresh1_field: assert property (clk_en && thr1_wr |=> thresh1_reg == $past(reg_wdata[7:3]))
        else $error("First shutoff threshold did not take the written value.");

    a_thresh2_field: assert property (clk_en && thr2_wr |=> thresh2_reg == $past(reg_wdata[7:3]))
        else $error("Second shutoff threshold did not take the written value.");

    a_level1_read: assert property (clk_en && reg_hit(reg_rd, reg_addr, `OFS_OUT1_LEVEL) |=>
        reg_rdata == $past(lif1.level))
        else $error("Lane 1 level read did not return the filter level.");

    a_level2_read: assert property (clk_en && reg_hit(reg_rd, reg_addr, `OFS_OUT2_LEVEL) |=>
        reg_rdata == $past(lif2.level))
        else $error("Lane 2 level read did not return the filter level.");

    a_unmapped_read: assert property (clk_en && reg_rd &&
        !(reg_addr inside {`OFS_SMOOTH_CFG, `OFS_OUT1_THRESH, `OFS_OUT2_THRESH, `OFS_OUT1_LEVEL, `OFS_OUT2_LEVEL})
        |=> reg_rdata == 8'h00)
        else $error("Unmapped address read as nonzero.");

    a_cfg_hold: assert property (!(clk_en && cfg_wr) |=> $stable(cfg_reg))
        else $error("Configuration register changed without a write.");

    a_freeze_out: assert property (!clk_en |=> $stable(out1_duty) && $stable(out2_duty) && $stable(reg_rdata))
        else $error("Outputs moved while the clock enable was low.");

    a_tick_period: assert property (clk_en && tick && gap_seen_reg |-> gap_reg == tick_cnt_t'(UPDATE_CYCLES - 1))
        else $error("Update ticks were not spaced by the update period.");

endmodule

// >>> design/smooth_cfg.svh
// Offsets, field positions, reset values and timing counts for the PWM duty smoothing filter.
//==============================================================================
//==============================================================================
`ifndef SMOOTH_CFG_SVH
`define SMOOTH_CFG_SVH

// Register byte offsets on the management port.
`define OFS_SMOOTH_CFG 8'h32
`define OFS_OUT1_THRESH 8'h33
`define OFS_OUT2_THRESH 8'h34
`define OFS_OUT1_LEVEL 8'h3a
`define OFS_OUT2_LEVEL 8'h3b

// Field positions inside the configuration and threshold registers.
`define COEF1_LSB 0
`define COEF1_MSB 2
`define COEF2_LSB 4
`define COEF2_MSB 6
`define CFG_WR_MASK 8'h77
`define THRESH_LSB 3
`define THRESH_MSB 7

// Reset values.
`define SMOOTH_CFG_RST 8'h00
`define THRESH_RST 5'h00

// Timebase: filter update period in microseconds and the clock rate in MHz.
`define CLK_FREQ_MHZ 20
`define UPDATE_PERIOD_US 22600
`define UPDATE_PERIOD_CYCLES (`UPDATE_PERIOD_US * `CLK_FREQ_MHZ)

// Nominal 95% settling times in milliseconds for codes 001 and 111.
`define SETTLE_CODE1_MS 98
`define SETTLE_CODE7_MS 8689

`endif

// >>> design/smooth_lane.sv
// One first-order recursive smoothing lane with low-duty shutoff.
`timescale 1ns/100ps
module smooth_lane
    import smooth_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    smooth_lane_if.lane lif
);

    acc_t acc_reg;
    duty_t out_reg;
    logic shut_reg;
    logic filt_on;
    logic shut_on;
    duty_t source;

    // One filter step: move the accumulator by the error shifted down by the code.
    function automatic acc_t iir_step(input acc_t acc, input duty_t x, input coef_t k);
        logic signed [16:0] diff;
        logic signed [16:0] step;
        logic signed [16:0] sum;
        diff = $signed({1'b0, x, 8'h00}) - $signed({1'b0, acc});
        step = diff >>> k;
        sum = $signed({1'b0, acc}) + step;
        iir_step = sum[15:0];
    endfunction

    //==========================================================================
    // Filter control decode
    // Smoothing acts only on low resolution sources with a nonzero code.
    assign filt_on = (lif.coef != 3'h0) && lif.lowres;
    assign source = filt_on ? acc_reg[15:8] : lif.duty_req;
    assign shut_on = (lif.coef != 3'h0) && (source < {lif.thresh, 3'h0});

    //==========================================================================
    // Accumulator: tracks the input when idle, steps once per update tick.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_reg <= 16'h0000;
        end else if (clk_en) begin
            if (!filt_on) begin
                acc_reg <= {lif.duty_req, 8'h00};
            end else if (lif.tick) begin
                acc_reg <= iir_step(acc_reg, lif.duty_req, lif.coef);
            end
        end
    end

    //==========================================================================
    // Registered duty output with shutoff forcing zero.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_reg <= 8'h00;
            shut_reg <= 1'b0;
        end else if (clk_en) begin
            out_reg <= shut_on ? 8'h00 : source;
            shut_reg <= shut_on;
        end
    end

    assign lif.level = acc_reg[15:8];
    assign lif.duty_out = out_reg;
    assign lif.shut = shut_reg;

endmodule

// >>> design/smooth_lane_if.sv
// Signals between the filter top and one smoothing lane.
`timescale 1ns/100ps
interface smooth_lane_if;
    import smooth_pkg::*;
    coef_t coef;
    thresh_t thresh;
    logic tick;
    duty_t duty_req;
    logic lowres;
    duty_t level;
    duty_t duty_out;
    logic shut;

    modport lane (input coef, input thresh, input tick, input duty_req, input lowres,
                  output level, output duty_out, output shut);
    modport top (output coef, output thresh, output tick, output duty_req, output lowres,
                 input level, input duty_out, input shut);
endinterface

// >>> design/smooth_pkg.sv
// Types shared by the PWM duty smoothing filter modules.
package smooth_pkg;

    typedef logic [2:0] coef_t;
    typedef logic [7:0] duty_t;
    typedef logic [4:0] thresh_t;
    typedef logic [15:0] acc_t;
    typedef logic [19:0] tick_cnt_t;

    // Distance between two duty values.
    function automatic duty_t duty_dist(input duty_t a, input duty_t b);
        duty_dist = (a > b) ? duty_t'(a - b) : duty_t'(b - a);
    endfunction

endpackage

// >>> design/smooth_tick.sv
// Update timebase that emits one enabled-cycle pulse per filter update period.
`timescale 1ns/100ps
module smooth_tick
    import smooth_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = 452000
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    output logic tick
);

    localparam tick_cnt_t LAST = tick_cnt_t'(PERIOD_CYCLES - 1);

    tick_cnt_t cnt_reg;
    logic tick_reg;

    //==========================================================================
    // Period counter
    // Counts down from the last value; tick is high for the cycle after wrap.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 20'h00000;
            tick_reg <= 1'b0;
        end else if (clk_en) begin
            tick_reg <= (cnt_reg == 20'h00000);
            cnt_reg <= (cnt_reg == 20'h00000) ? LAST : tick_cnt_t'(cnt_reg - 20'h00001);
        end
    end

    assign tick = tick_reg;

endmodule

// >>> verif/testbench.sv
// Self-checking testbench for the two-output PWM duty smoothing filter.
`timescale 1ns/100ps
`include "smooth_cfg.svh"
module testbench;
    import smooth_pkg::*;

    //==========================================================================
    // Signals and design instance
    //==========================================================================
    localparam int unsigned UPD = 8;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] out1_duty_req = 8'h00;
    logic out1_lowres = 1'b0;
    logic [7:0] out2_duty_req = 8'h00;
    logic out2_lowres = 1'b0;
    logic [7:0] out1_duty;
    logic out1_shut;
    logic [7:0] out2_duty;
    logic out2_shut;
    int n_mismatch = 0;
    int tests_run = 0;

    pwm_duty_smoothing_filter #(.UPDATE_CYCLES(UPD)) pwm_duty_smoothing_filter_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .out1_duty_req(out1_duty_req), .out1_lowres(out1_lowres),
        .out2_duty_req(out2_duty_req), .out2_lowres(out2_lowres),
        .out1_duty(out1_duty), .out1_shut(out1_shut),
        .out2_duty(out2_duty), .out2_shut(out2_shut)
    );

    // Clock of 50 ns period.
    always #25 sys_clk = ~sys_clk;

    //==========================================================================
    // Shared tasks
    //==========================================================================
    // Compares a seen value with the expected one and reports a mismatch.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic print_verdict();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // Upper byte of an accumulator stepped n times toward full scale.
    function automatic logic [7:0] lvl(input int c, input int n);
        logic [15:0] acc;
        acc = 16'h0000;
        repeat (n) acc = acc + ((16'hff00 - acc) >> c);
        return acc[15:8];
    endfunction

    //==========================================================================
    // Scenarios
    //==========================================================================
    // Reset values, a reset in mid-run, reserved bits and an unmapped address.
    task automatic t_regs();
        rd_chk(`OFS_SMOOTH_CFG, 8'h00);
        rd_chk(8'h40, 8'h00);
        wr(`OFS_SMOOTH_CFG, 8'hff);
        rd_chk(`OFS_SMOOTH_CFG, 8'h77);
        wr(`OFS_SMOOTH_CFG, 8'h15);
        rd_chk(`OFS_SMOOTH_CFG, 8'h15);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd_chk(`OFS_SMOOTH_CFG, 8'h00);
        wr(`OFS_OUT1_THRESH, 8'hff);
        rd_chk(`OFS_OUT1_THRESH, 8'hf8);
        wr(`OFS_OUT2_THRESH, 8'hff);
        rd_chk(`OFS_OUT2_THRESH, 8'hf8);
    endtask

    // Bypass passes duty unchanged, never shuts, and freezes with the enable low.
    task automatic t_bypass();
        @(posedge sys_clk);
        out1_lowres <= 1'b1;
        out2_lowres <= 1'b1;
        out1_duty_req <= 8'h5a;
        out2_duty_req <= 8'h0a;
        @(posedge sys_clk);
        #1 chk(out1_duty, 8'h5a);
        chk(out2_duty, 8'h0a);
        chk({6'h00, out2_shut, out1_shut}, 8'h00);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        out1_duty_req <= 8'h33;
        repeat (3) @(posedge sys_clk);
        #1 chk(out1_duty, 8'h5a);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk(out1_duty, 8'h33);
        rd_chk(`OFS_OUT1_LEVEL, 8'h33);
        rd_chk(`OFS_OUT2_LEVEL, 8'h0a);
    endtask

    // Shutoff works once a coefficient is set, on high-resolution sources too.
    task automatic t_shut();
        @(posedge sys_clk);
        out1_lowres <= 1'b0;
        out2_lowres <= 1'b0;
        out1_duty_req <= 8'h10;
        out2_duty_req <= 8'hff;
        wr(`OFS_SMOOTH_CFG, 8'h11);
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h00, out1_shut}, 8'h01);
        chk(out1_duty, 8'h00);
        chk({7'h00, out2_shut}, 8'h00);
        chk(out2_duty, 8'hff);
        wr(`OFS_SMOOTH_CFG, 8'h10);
        out2_duty_req <= 8'h20;
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h00, out1_shut}, 8'h00);
        chk(out1_duty, 8'h10);
        chk({7'h00, out2_shut}, 8'h01);
    endtask

    // Every nonzero code, code c on output 1 and 8 - c on output 2, settles at its own rate.
    task automatic t_codes();
        logic ok1;
        logic ok2;
        wr(`OFS_OUT1_THRESH, 8'h00);
        wr(`OFS_OUT2_THRESH, 8'h00);
        for (int c = 1; c < 8; c++) begin
            wr(`OFS_SMOOTH_CFG, 8'h00);
            @(posedge sys_clk);
            out1_duty_req <= 8'h00;
            out2_duty_req <= 8'h00;
            out1_lowres <= 1'b1;
            out2_lowres <= 1'b1;
            repeat (3) @(posedge sys_clk);
            wr(`OFS_SMOOTH_CFG, {1'b0, 3'(8 - c), 1'b0, 3'(c)});
            out1_duty_req <= 8'hff;
            out2_duty_req <= 8'hff;
            repeat (28) @(posedge sys_clk);
            #1 ok1 = (out1_duty >= lvl(c, 3)) && (out1_duty <= lvl(c, 4));
            ok2 = (out2_duty >= lvl(8 - c, 3)) && (out2_duty <= lvl(8 - c, 4));
            chk({7'h00, ok1}, 8'h01);
            chk({7'h00, ok2}, 8'h01);
        end
    endtask

    //==========================================================================
    // Main sequence and watchdog
    //==========================================================================
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_regs();
        t_bypass();
        t_shut();
        t_codes();
        print_verdict();
    end

    // Cuts a hung run short and counts it as a mismatch.
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict();
    end

endmodule
